// File: shared/scl_params.svh
// Constants for the set-associative cache lookup block.
// Assumes includers want plain macros; no logic lives here.
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH
`define SCL_LINE_WORDS    8
`define SCL_LINE_BYTES    32
`define SCL_OFF_LSB       5
`define SCL_HALF_BIT      2
`define SCL_ADDR_CTRL     12'h000
`define SCL_ADDR_STATUS   12'h004
`define SCL_ADDR_ENTRY    12'h008
`define SCL_CTRL_EN       0
`define SCL_CTRL_PRED     1
`define SCL_CTRL_LOCK_LSB 2
`define SCL_CTRL_WBUF     4
`define SCL_CTRL_RESET    32'h0000_0000
`define SCL_ENT_VALID     4
`define SCL_ENT_DIRTY_LSB 2
`define SCL_LFSR_SEED     8'h5A
`endif

// File: shared/scl_pkg.sv
// Types for the set-associative cache lookup block.
// Assumes scl_params.svh supplies the numeric constants.
package scl_pkg;
  typedef enum logic [2:0]
  {
    SCL_IDLE   = 3'h0,
    SCL_EVICT  = 3'h1,
    SCL_FILL   = 3'h3,
    SCL_SINGLE = 3'h2,
    SCL_WBUF   = 3'h6
  } scl_state_type;

  typedef struct packed
  {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        cacheable;
    logic        bufferable;
  } scl_core_req_type;

  typedef struct packed
  {
    logic        req;
    logic        write;
    logic        burst;
    logic [31:0] addr;
    logic [31:0] wdata;
  } scl_mem_req_type;
endpackage

// File: rtl/scl_cache.sv
// One cache (instruction or data) with tag compare, fill and eviction.
// Assumes core holds its request until core_ready, memory acks each word.
`timescale 1ns/100ps
`include "scl_params.svh"
module scl_cache
#(
  parameter int SIZE_KB = 4,
  parameter int WAYS    = 4,
  parameter bit IS_DATA = 1'b1
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire scl_pkg::scl_core_req_type core_in,
  output logic      [31:0]               core_rdata,
  output logic                           core_ready,
  output scl_pkg::scl_mem_req_type       mem_out,
  input  wire logic                      mem_ack,
  input  wire logic [31:0]               mem_rdata,
  output logic                           wb_valid,
  output logic      [31:0]               wb_addr,
  output logic      [31:0]               wb_data,
  input  wire logic                      wb_ready
);
  // Geometry; index width follows size and ways
  localparam int LINES = SIZE_KB * 1024 / `SCL_LINE_BYTES;
  localparam int SETS  = (LINES / WAYS) > 1 ? LINES / WAYS : 2;
  localparam int IDX_W = $clog2(SETS);
  localparam int TAG_W = 32 - `SCL_OFF_LSB - IDX_W;
  localparam bit PRESENT = (SIZE_KB != 0);
  scl_pkg::scl_state_type state;
  logic [31:0]             ctrl;
  logic [TAG_W-1:0]        tag_mem [WAYS][SETS];
  logic [31:0]             data_mem [WAYS][SETS*`SCL_LINE_WORDS];
  logic [WAYS-1:0]         valid [SETS];
  logic [1:0]              dirty [WAYS][SETS];
  logic [WAYS-1:0]         way_hit;
  logic [31:0]             hit_data;
  logic [1:0]              hit_way;
  logic [TAG_W-1:0]        acc_tag;
  logic [IDX_W-1:0]        acc_idx;
  logic [2:0]              acc_word;
  logic                    cache_on;
  logic                    take;
  logic                    any_hit;
  logic [1:0]              victim;
  logic [1:0]              vic;
  logic [1:0]              lock_base;
  logic [7:0]              lfsr;
  logic [1:0]              pred_cnt;
  logic [1:0]              cand;
  logic [3:0]              ev_cnt;
  logic [2:0]              fill_cnt;
  logic                    fill_we;
  logic                    hit_we;
  logic [31:0]             last_entry;
  // Address split
  assign acc_word = core_in.addr[4:2];
  assign acc_idx  = core_in.addr[`SCL_OFF_LSB +: IDX_W];
  assign acc_tag  = core_in.addr[31 -: TAG_W];
  assign cache_on = PRESENT && ctrl[`SCL_CTRL_EN];
  assign take     = (state == scl_pkg::SCL_IDLE) && core_in.req && !core_ready;
  // Parallel tag compare; zero size or invalid never hits
  for (genvar g = 0; g < WAYS; g++)
  begin : g_way
    assign way_hit[g] = cache_on && valid[acc_idx][g] && (tag_mem[g][acc_idx] == acc_tag);
  end
  assign any_hit = |way_hit;
  always_comb
  begin
    hit_data = 32'h0000_0000;
    hit_way  = 2'h0;
    for (int w = 0; w < WAYS; w++)
    begin
      if (way_hit[w])
      begin
        hit_data = data_mem[w][{acc_idx, acc_word}];
        hit_way  = w[1:0];
      end
    end
  end

  // Victim choice within unlocked ways
  assign lock_base = (WAYS == 1) ? 2'h0 : ctrl[`SCL_CTRL_LOCK_LSB +: 2] & 2'(WAYS - 1);
  assign cand      = (ctrl[`SCL_CTRL_PRED] ? pred_cnt : lfsr[1:0]) & 2'(WAYS - 1);
  assign victim    = (cand < lock_base) ? lock_base : cand;

  // Random source runs every clock, so victims are not tied to access pattern
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lfsr <= `SCL_LFSR_SEED;
    else
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end

  // Predictable counter steps once per allocation and wraps to lock base
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pred_cnt <= 2'h0;
    else if (take && !any_hit && !core_in.write && core_in.cacheable && cache_on)
      pred_cnt <= (victim == 2'(WAYS - 1)) ? lock_base : victim + 2'h1;
  end

  // Storage writes; memories carry no reset
  assign fill_we = (state == scl_pkg::SCL_FILL) && mem_ack;
  assign hit_we  = take && core_in.write && any_hit && core_in.cacheable;
  always_ff @(posedge pclk)
  begin
    if (fill_we)
      data_mem[vic][{acc_idx, fill_cnt}] <= mem_rdata;
    else if (hit_we)
      data_mem[hit_way][{acc_idx, acc_word}] <= core_in.wdata;
    if (fill_we && fill_cnt == 3'h7)
      tag_mem[vic][acc_idx] <= acc_tag;
  end

  // Status bits; reset invalidates every line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        valid[s] <= '0;
        for (int w = 0; w < WAYS; w++)
          dirty[w][s] <= 2'h0;
      end
    end
    else if (fill_we && fill_cnt == 3'h7)
    begin
      valid[acc_idx][vic] <= 1'b1;
      dirty[vic][acc_idx] <= 2'h0;
    end
    else if (hit_we && IS_DATA && core_in.bufferable)
      dirty[hit_way][acc_idx][acc_word[`SCL_HALF_BIT]] <= 1'b1;
  end

  // Main sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= scl_pkg::SCL_IDLE;
      core_ready <= 1'b0;
      core_rdata <= 32'h0000_0000;
      mem_out    <= '0;
      wb_valid   <= 1'b0;
      wb_addr    <= 32'h0000_0000;
      wb_data    <= 32'h0000_0000;
      vic        <= 2'h0;
      ev_cnt     <= 4'h0;
      fill_cnt   <= 3'h0;
    end
    else
    begin
      core_ready <= 1'b0;
      unique case (state)
        scl_pkg::SCL_IDLE:
        begin
          if (take)
          begin
            if (any_hit && core_in.cacheable && !core_in.write)
            begin
              core_rdata <= hit_data;
              core_ready <= 1'b1;
            end
            else if (any_hit && core_in.cacheable && core_in.bufferable)
              core_ready <= 1'b1; // Write-back hit stays in cache
            else if (!core_in.write && core_in.cacheable && cache_on)
            begin
              vic    <= victim;
              ev_cnt <= 4'h0;
              fill_cnt <= 3'h0;
              if (IS_DATA && valid[acc_idx][victim] && |dirty[victim][acc_idx])
                state <= scl_pkg::SCL_EVICT;
              else
              begin
                state   <= scl_pkg::SCL_FILL;
                mem_out <= '{req: 1'b1, write: 1'b0, burst: 1'b1,
                             addr: {core_in.addr[31:5], 5'h00}, wdata: 32'h0000_0000};
              end
            end
            else if (core_in.write && core_in.bufferable && ctrl[`SCL_CTRL_WBUF])
            begin
              state    <= scl_pkg::SCL_WBUF;
              wb_valid <= 1'b1;
              wb_addr  <= core_in.addr;
              wb_data  <= core_in.wdata;
            end
            else
            begin
              state   <= scl_pkg::SCL_SINGLE;
              mem_out <= '{req: 1'b1, write: core_in.write, burst: 1'b0,
                           addr: core_in.addr, wdata: core_in.wdata};
            end
          end
        end
        scl_pkg::SCL_EVICT:
        begin
          // Only dirty halves are pushed; clean halves are skipped
          if (!(wb_valid && !wb_ready))
          begin
            if (ev_cnt[3])
            begin
              wb_valid <= 1'b0;
              state    <= scl_pkg::SCL_FILL;
              mem_out  <= '{req: 1'b1, write: 1'b0, burst: 1'b1,
                            addr: {core_in.addr[31:5], 5'h00}, wdata: 32'h0000_0000};
            end
            else if (dirty[vic][acc_idx][ev_cnt[2]])
            begin
              wb_valid <= 1'b1;
              wb_addr  <= {tag_mem[vic][acc_idx], acc_idx, ev_cnt[2:0], 2'h0};
              wb_data  <= data_mem[vic][{acc_idx, ev_cnt[2:0]}];
              ev_cnt   <= ev_cnt + 4'h1;
            end
            else
            begin
              wb_valid <= 1'b0;
              ev_cnt   <= ev_cnt + 4'h4;
            end
          end
        end
        scl_pkg::SCL_FILL:
        begin
          if (mem_ack)
          begin
            fill_cnt <= fill_cnt + 3'h1;
            if (fill_cnt == acc_word)
              core_rdata <= mem_rdata;
            if (fill_cnt == 3'h7)
            begin
              mem_out.req <= 1'b0; // Line complete
              core_ready  <= 1'b1;
              state       <= scl_pkg::SCL_IDLE;
            end
          end
        end
        scl_pkg::SCL_SINGLE:
        begin
          if (mem_ack)
          begin
            mem_out.req <= 1'b0;
            core_rdata  <= mem_rdata;
            core_ready  <= 1'b1;
            state       <= scl_pkg::SCL_IDLE;
          end
        end
        scl_pkg::SCL_WBUF:
        begin
          if (wb_ready)
          begin
            wb_valid   <= 1'b0;
            core_ready <= 1'b1;
            state      <= scl_pkg::SCL_IDLE;
          end
        end
        default:
          state <= scl_pkg::SCL_IDLE;
      endcase
    end
  end

  // Last looked-up entry in tag-entry layout, for software inspection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_entry <= 32'h0000_0000;
    else if (take)
    begin
      last_entry <= 32'h0000_0000;
      last_entry[`SCL_ENT_VALID] <= any_hit;
      last_entry[`SCL_ENT_DIRTY_LSB +: 2] <= any_hit ? dirty[hit_way][acc_idx] : 2'h0;
      last_entry[1:0] <= any_hit ? hit_way : victim;
    end
  end

  // APB slave: one wait state, unmapped reads give zero and an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= `SCL_CTRL_RESET;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && !penable)
      begin
        pslverr <= !(paddr == `SCL_ADDR_CTRL || paddr == `SCL_ADDR_STATUS || paddr == `SCL_ADDR_ENTRY);
        unique case (paddr)
          `SCL_ADDR_CTRL:   prdata <= ctrl;
          `SCL_ADDR_STATUS: prdata <= {21'h0, IS_DATA, PRESENT, 2'(WAYS - 1), victim, 2'b00, state};
          `SCL_ADDR_ENTRY:  prdata <= last_entry;
          default:          prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && penable && pready && pwrite && paddr == `SCL_ADDR_CTRL)
        ctrl <= pwdata & 32'h0000_001F;
    end
  end

  a_hit_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    take && any_hit && core_in.cacheable && !core_in.write |=> core_ready && core_rdata == $past(hit_data))
    else $error("read hit not answered next cycle");
  a_zero_never_hits: assert property (@(posedge pclk) disable iff (!presetn)
    take && !cache_on |=> state == scl_pkg::SCL_SINGLE || state == scl_pkg::SCL_WBUF)
    else $error("access hit or allocated while cache absent or off");
  a_victim_unlocked: assert property (@(posedge pclk) disable iff (!presetn)
    state == scl_pkg::SCL_FILL |-> vic >= lock_base)
    else $error("locked way chosen as victim");
  a_miss_goes_out: assert property (@(posedge pclk) disable iff (!presetn)
    take && !any_hit && !(core_in.write && core_in.bufferable && ctrl[`SCL_CTRL_WBUF]) |=> mem_out.req || state == scl_pkg::SCL_EVICT)
    else $error("miss without external access");
  a_buffered_write: assert property (@(posedge pclk) disable iff (!presetn)
    take && core_in.write && !(any_hit && core_in.cacheable && core_in.bufferable) && core_in.bufferable && ctrl[`SCL_CTRL_WBUF]
    |=> wb_valid && !mem_out.req)
    else $error("buffered write did not use buffer");
  a_fill_eight_words: assert property (@(posedge pclk) disable iff (!presetn)
    state == scl_pkg::SCL_FILL && mem_ack && fill_cnt == 3'h7 |=> valid[$past(acc_idx)][$past(vic)] && core_ready)
    else $error("line not validated after eighth word");
  a_wt_no_dirty: assert property (@(posedge pclk) disable iff (!presetn)
    hit_we && !core_in.bufferable |=> dirty[$past(hit_way)][$past(acc_idx)] == $past(dirty[hit_way][acc_idx]))
    else $error("write-through store set dirty");
  a_evict_before_fill: assert property (@(posedge pclk) disable iff (!presetn)
    state == scl_pkg::SCL_EVICT |-> !mem_out.req && !fill_we)
    else $error("fill overlapped eviction");
  a_direct_no_lock: assert property (@(posedge pclk) disable iff (!presetn)
    WAYS == 1 |-> lock_base == 2'h0)
    else $error("lockdown active on direct-mapped cache");
endmodule

// File: tb/scl_mem_model.sv
// External memory and write buffer partner for one cache.
// Assumes the cache holds mem_out.req until its last ack.
`timescale 1ns/100ps
module scl_mem_model
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     slow,
  input  wire scl_pkg::scl_mem_req_type mem_out,
  output logic                          mem_ack,
  output logic      [31:0]              mem_rdata,
  output logic                          wb_ready
);
  logic [3:0] beat;
  logic [1:0] gap;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      beat      <= 4'h0;
      gap       <= 2'h0;
      wb_ready  <= 1'b0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      // Junk between beats so a stale word never looks valid
      mem_rdata <= ~mem_rdata;
      wb_ready  <= slow ? ~wb_ready : 1'b1;
      if (!mem_out.req)
        beat <= 4'h0;
      else if (!mem_ack && beat < (mem_out.burst ? 4'h8 : 4'h1))
      begin
        if (gap != 2'h0)
          gap <= gap - 2'h1;
        else
        begin
          mem_ack   <= 1'b1; // Line words 0..7 from base
          mem_rdata <= (mem_out.addr + {26'h0, beat, 2'h0}) ^ 32'hA5A5_0000;
          beat      <= beat + 4'h1;
          gap       <= slow ? 2'h2 : 2'h0;
        end
      end
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for one 4 KB 4-way data cache.
// Assumes scl_mem_model stands in for memory and write buffer.
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, core_rdata, mem_rdata, wb_addr, wb_data;
  logic pready, pslverr, core_ready, mem_ack, wb_valid, wb_ready;
  scl_pkg::scl_core_req_type core_in;
  scl_pkg::scl_mem_req_type  mem_out, last_mem;
  int failures, n_tests;
  int n_acks = 0;
  logic [31:0] wq_a[$], wq_d[$];

  scl_cache #(.SIZE_KB(4), .WAYS(4), .IS_DATA(1'b1)) uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_in(core_in),
    .core_rdata(core_rdata), .core_ready(core_ready), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wb_valid(wb_valid),
    .wb_addr(wb_addr), .wb_data(wb_data), .wb_ready(wb_ready)
  );

  scl_mem_model mem
  (
    .pclk(pclk), .presetn(presetn), .slow(slow), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .wb_ready(wb_ready)
  );

  // Traffic seen on the far side, sampled at the edge
  always @(posedge pclk)
  begin
    if (mem_ack === 1'b1)
      n_acks++;
    if (mem_out.req === 1'b1)
      last_mem <= mem_out;
    if (wb_valid === 1'b1 && wb_ready === 1'b1)
    begin
      wq_a.push_back(wb_addr);
      wq_d.push_back(wb_data);
    end
  end

  function automatic logic [31:0] mw(input logic [31:0] a);
    return a ^ 32'hA5A5_0000;
  endfunction

  task end_of_test;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task expired;
    failures++;
    $display("Error wait expired");
    end_of_test;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
      expired;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task ctrl(input logic [31:0] v);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 12'h000, v, rd, er);
  endtask

  task core(input logic w, input logic [31:0] a, input logic [31:0] d,
            input logic c, input logic b, output logic [31:0] rd, output int n);
    @(posedge pclk);
    core_in <= '{req: 1'b1, write: w, addr: a, wdata: d, cacheable: c, bufferable: b};
    for (n = 1; n < 300; n++)
    begin
      @(posedge pclk);
      if (core_ready === 1'b1)
        break;
    end
    if (n == 300)
      expired;
    rd = core_rdata;
    core_in.req <= 1'b0;
  endtask

  task t_regs;
    logic [31:0] rd;
    logic        er;
    int          n, a0;
    apb(1'b0, 12'h000, 32'h0000_0000, rd, er);
    check("ctrl reset", rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000, rd, er);
    check("status shape", {28'h0, rd[10:7]}, 32'h0000_000F);
    apb(1'b0, 12'h00C, 32'h0000_0000, rd, er);
    check("unmapped err", {31'h0, er}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    a0 = n_acks;
    core(1'b0, 32'h0000_0104, 32'h0, 1'b1, 1'b1, rd, n);
    check("disabled read", rd, mw(32'h0000_0104));
    check("disabled single", n_acks - a0, 1);
    $display("register test done");
  endtask

  task t_fill;
    logic [31:0] rd, a;
    logic        er;
    int          n, a0;
    ctrl(32'h0000_0003);
    for (int k = 0; k < 4; k++)
    begin
      a  = 32'h0000_0044 + k * 32'h400;
      a0 = n_acks;
      core(1'b0, a, 32'h0, 1'b1, 1'b1, rd, n);
      check("fill word", rd, mw(a));
      check("fill beats", n_acks - a0, 8);
      check("fill burst", {31'h0, last_mem.burst}, 32'h1);
      check("fill base", last_mem.addr, a & 32'hFFFF_FFE0);
    end
    for (int k = 0; k < 4; k++)
    begin
      a = 32'h0000_004C + k * 32'h400;
      core(1'b0, a, 32'h0, 1'b1, 1'b1, rd, n);
      check("hit cycles", n, 2);
      check("hit data", rd, mw(a));
    end
    apb(1'b0, 12'h008, 32'h0, rd, er);
    check("entry valid", {31'h0, rd[4]}, 32'h1);
    $display("fill test done");
  endtask

  task t_lock;
    logic [31:0] rd;
    int          n, a0, h;
    slow <= 1'b1;
    ctrl(32'h0000_000F);
    core(1'b0, 32'h0000_1044, 32'h0, 1'b1, 1'b1, rd, n);
    core(1'b0, 32'h0000_1444, 32'h0, 1'b1, 1'b1, rd, n);
    a0 = n_acks;
    core(1'b1, 32'h0000_1454, 32'hDEAD_0001, 1'b1, 1'b1, rd, n);
    check("wb store cycles", n, 2);
    check("wb store quiet", n_acks - a0, 0);
    core(1'b0, 32'h0000_1454, 32'h0, 1'b1, 1'b1, rd, n);
    check("store readback", rd, 32'hDEAD_0001);
    apb(1'b0, 12'h008, 32'h0, rd, n[0]);
    check("one half dirty", {31'h0, rd[3] ^ rd[2]}, 32'h1);
    wq_a.delete();
    wq_d.delete();
    core(1'b0, 32'h0000_1844, 32'h0, 1'b1, 1'b1, rd, n);
    check("evict count", wq_a.size(), 4);
    for (int i = 0; i < 4 && i < wq_a.size(); i++)
    begin
      check("evict addr", wq_a[i], 32'h0000_1450 + 4 * i);
      check("evict data", wq_d[i], i == 1 ? 32'hDEAD_0001 : mw(32'h0000_1450 + 4 * i));
    end
    h = 0;
    for (int k = 0; k < 4; k++)
    begin
      core(1'b0, 32'h0000_0048 + k * 32'h400, 32'h0, 1'b1, 1'b1, rd, n);
      if (n == 2)
        h++;
    end
    check("locked hits", h, 3);
    slow <= 1'b0;
    $display("lockdown test done");
  endtask

  task t_uncached;
    logic [31:0] rd;
    int          n, a0;
    a0 = n_acks;
    core(1'b0, 32'h0000_2000, 32'h0, 1'b0, 1'b0, rd, n);
    core(1'b0, 32'h0000_2000, 32'h0, 1'b0, 1'b0, rd, n);
    check("uncached data", rd, mw(32'h0000_2000));
    check("uncached no alloc", n_acks - a0, 2);
    core(1'b1, 32'h0000_2004, 32'h0BAD_F00D, 1'b1, 1'b0, rd, n);
    check("wt miss write", {31'h0, last_mem.write}, 32'h1);
    check("wt miss addr", last_mem.addr, 32'h0000_2004);
    check("wt miss data", last_mem.wdata, 32'h0BAD_F00D);
    ctrl(32'h0000_001F);
    wq_a.delete();
    wq_d.delete();
    a0 = n_acks;
    core(1'b1, 32'h0000_2008, 32'h1357_9BDF, 1'b0, 1'b1, rd, n);
    check("buffered no mem", n_acks - a0, 0);
    check("buffered count", wq_a.size(), 1);
    check("buffered addr", wq_a.size() > 0 ? wq_a[0] : 32'h0, 32'h0000_2008);
    core(1'b1, 32'h0000_0040, 32'h1234_5678, 1'b1, 1'b0, rd, n);
    core(1'b0, 32'h0000_0040, 32'h0, 1'b1, 1'b0, rd, n);
    check("wt hit data", rd, 32'h1234_5678);
    apb(1'b0, 12'h008, 32'h0, rd, n[0]);
    check("wt never dirty", {30'h0, rd[3:2]}, 32'h0);
    ctrl(32'h0000_0011);
    a0 = n_acks;
    core(1'b0, 32'h0000_3064, 32'h0, 1'b1, 1'b1, rd, n);
    check("random fill beats", n_acks - a0, 8);
    check("random fill word", rd, mw(32'h0000_3064));
    core(1'b0, 32'h0000_3068, 32'h0, 1'b1, 1'b1, rd, n);
    check("random hit cycles", n, 2);
    check("random hit data", rd, mw(32'h0000_3068));
    $display("uncached test done");
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    slow     = 1'b0;
    core_in  = '0;
    failures = 0;
    n_tests  = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_fill;
    t_lock;
    t_uncached;
    end_of_test;
  end
endmodule
